// ==== shared/dcs_consts.svh ====
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

`define DCS_MOTORS 3
`define DCS_RAM_SEL_BIT 8
`define DCS_REG_CTRL 6'h00
`define DCS_REG_STATUS 6'h01
`define DCS_REG_RXDATA 6'h02
`define DCS_REG_DGCNT 6'h03

`define DCS_CTRL_START 0
`define DCS_CTRL_LAST_LO 2
`define DCS_CTRL_SCK_POL 4
`define DCS_CTRL_NCS_POL 5
`define DCS_CTRL_DIV_LO 8

`define DCS_ST_BUSY 0
`define DCS_ST_PEND 1
`define DCS_ST_DAC_LO 4
`define DCS_ST_WP_LO 8

`define DCS_RST_LAST 2'h2
`define DCS_RST_DIV 8'h0f

`define DCS_NXM_BIT 5
`define DCS_CODE_ZERO 5'h10
`define DCS_CODE_ONE 5'h11
`define DCS_CODE_DIR 5'h12
`define DCS_CODE_STEP 5'h13
`define DCS_GRP_A 2'h0
`define DCS_GRP_B 2'h1
`define DCS_SEL_POL 3'h6
`define DCS_SEL_FD 3'h7
`define DCS_QUARTER 8'h40

`endif

// ==== shared/dcs_pkg.sv ====
package dcs_pkg;
  typedef logic [63:0][11:0] dcs_ram_t;

  typedef struct packed {
    logic [5:0] dac_a;
    logic [5:0] dac_b;
    logic pol_a;
    logic pol_b;
    logic fd_a;
    logic fd_b;
    logic dir;
    logic step;
  } dcs_snap_t;

  typedef enum logic [1:0] {L_IDLE, L_LOW, L_HIGH, L_END} dcs_lstate_t;
  typedef enum logic [1:0] {S_IDLE, S_SEND} dcs_sstate_t;

  typedef struct packed {
    dcs_lstate_t state;
    logic [7:0] cnt;
    logic sck;
    logic sdo;
    logic ncs_n;
    logic last;
    logic s1;
    logic s2;
    logic s3;
    logic sdi_f;
    logic [31:0] rx;
  } dcs_link_st_t;

  typedef struct packed {
    dcs_ram_t ram;
    logic [1:0] last_idx;
    logic [7:0] clk_div;
    logic sck_pol;
    logic ncs_pol;
    dcs_sstate_t state;
    logic [5:0] wp;
    logic [1:0] dac;
    logic pend;
    logic [15:0] dgcnt;
    dcs_snap_t [2:0] snap;
    logic ack;
    logic [31:0] dat;
  } dcs_top_st_t;
endpackage

// ==== rtl/dcs_link.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcs_link
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Configuration
  input wire logic [7:0] clk_div,
  input wire logic sck_pol,
  input wire logic ncs_pol,
  // Bit stream from sequencer
  input wire logic bit_valid,
  input wire logic bit_data,
  input wire logic bit_last,
  output logic bit_take,
  output logic link_idle,
  output logic [31:0] rx_data,
  // Chain pins
  input wire logic chain_sdi,
  output logic chain_sck,
  output logic chain_sdo,
  output logic chain_sel
);
  dcs_link_st_t q, d;
  logic take;

  always_comb begin
    d = q;
    take = 1'b0;
    d.s1 = chain_sdi;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.sdi_f = q.s3;
    end
    unique case (q.state)
      L_IDLE: begin
        d.sck = sck_pol;
        d.ncs_n = 1'b1;
        take = bit_valid;
      end
      L_LOW: begin
        if (q.cnt == 8'h00) begin
          d.sck = ~sck_pol;
          d.state = L_HIGH;
          d.cnt = clk_div;
          // Take the value agreed at this edge, else a bit arrives late
          d.rx = {q.rx[30:0], d.sdi_f};
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      L_HIGH: begin
        if (q.cnt == 8'h00) begin
          d.sck = sck_pol;
          if (q.last) begin
            d.state = L_END;
            d.cnt = clk_div;
          end else begin
            // Holds clock idle if the sequencer is late
            take = bit_valid;
          end
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      L_END: begin
        if (q.cnt == 8'h00) begin
          d.state = L_IDLE;
          d.ncs_n = 1'b1;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
    endcase
    if (take) begin
      d.sdo = bit_data;
      d.last = bit_last;
      d.ncs_n = 1'b0;
      d.state = L_LOW;
      d.cnt = clk_div;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{state: L_IDLE, ncs_n: 1'b1, s1: 1'b1, s2: 1'b1, s3: 1'b1,
             sdi_f: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign bit_take = take;
  assign link_idle = (q.state == L_IDLE);
  assign rx_data = q.rx;
  assign chain_sck = q.sck;
  assign chain_sdo = q.sdo;
  assign chain_sel = q.ncs_n ^ ncs_pol;
endmodule
`default_nettype wire

// ==== rtl/dcs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dcs_consts.svh"
module dcs_sequencer
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Motor signals from microstep unit
  input wire logic [2:0][7:0] motor_pos,
  input wire logic [2:0] motor_dir,
  input wire logic [2:0] motor_step,
  input wire logic [2:0] motor_fd_a,
  input wire logic [2:0] motor_fd_b,
  input wire logic xmit_req,
  // Driver chain pins
  input wire logic chain_sdi,
  output logic chain_sck,
  output logic chain_sdo,
  output logic chain_sel
);
  dcs_top_st_t q, d;
  dcs_snap_t [2:0] live;
  logic bit_take;
  logic link_idle;
  logic [31:0] rx_data;
  logic [5:0] cur_word;
  logic cur_bit;
  logic cur_last;
  logic seq_valid;

  // Quarter table lives in the upper half of the RAM
  function automatic logic [6:0] coil_lut(input logic [7:0] pos,
                                          input dcs_ram_t ram);
    logic [5:0] idx;
    logic [5:0] adr;
    logic [5:0] mag;
    idx = pos[6] ? ~pos[5:0] : pos[5:0];
    adr = {1'b1, idx[5:1]};
    mag = idx[0] ? ram[adr][11:6] : ram[adr][5:0];
    coil_lut = {pos[7], mag};
  endfunction

  function automatic logic pick_bit(input logic [4:0] code,
                                    input dcs_snap_t s);
    logic b;
    b = 1'b0;
    if (code[4:3] == `DCS_GRP_A) begin
      if (code[2:0] == `DCS_SEL_POL) begin
        b = s.pol_a;
      end else if (code[2:0] == `DCS_SEL_FD) begin
        b = s.fd_a;
      end else begin
        b = s.dac_a[code[2:0]];
      end
    end else if (code[4:3] == `DCS_GRP_B) begin
      if (code[2:0] == `DCS_SEL_POL) begin
        b = s.pol_b;
      end else if (code[2:0] == `DCS_SEL_FD) begin
        b = s.fd_b;
      end else begin
        b = s.dac_b[code[2:0]];
      end
    end else begin
      unique case (code)
        `DCS_CODE_ZERO: b = 1'b0;
        `DCS_CODE_ONE: b = 1'b1;
        `DCS_CODE_DIR: b = s.dir;
        `DCS_CODE_STEP: b = s.step;
        default: b = 1'b0;
      endcase
    end
    pick_bit = b;
  endfunction

  // One signal set per motor, all from the same table
  for (genvar m = 0; m < `DCS_MOTORS; m++) begin : g_motor
    logic [6:0] coil_a;
    logic [6:0] coil_b;
    assign coil_a = coil_lut(motor_pos[m], q.ram);
    assign coil_b = coil_lut(motor_pos[m] + `DCS_QUARTER, q.ram);
    assign live[m] = '{dac_a: coil_a[5:0], dac_b: coil_b[5:0],
                       pol_a: coil_a[6], pol_b: coil_b[6],
                       fd_a: motor_fd_a[m], fd_b: motor_fd_b[m],
                       dir: motor_dir[m], step: motor_step[m]};
  end

  // Even word in the low half, odd word in the high half
  assign cur_word = q.wp[0] ? q.ram[{1'b0, q.wp[5:1]}][11:6]
                            : q.ram[{1'b0, q.wp[5:1]}][5:0];
  assign cur_bit = pick_bit(cur_word[4:0], q.snap[q.dac]);
  assign cur_last = cur_word[`DCS_NXM_BIT] && (q.dac == q.last_idx);
  assign seq_valid = (q.state == S_SEND);

  dcs_link u_link (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_div(q.clk_div),
    .sck_pol(q.sck_pol),
    .ncs_pol(q.ncs_pol),
    .bit_valid(seq_valid),
    .bit_data(cur_bit),
    .bit_last(cur_last),
    .bit_take(bit_take),
    .link_idle(link_idle),
    .rx_data(rx_data),
    .chain_sdi(chain_sdi),
    .chain_sck(chain_sck),
    .chain_sdo(chain_sdo),
    .chain_sel(chain_sel)
  );

  always_comb begin
    logic req;
    logic wr;
    logic go;
    logic launch;
    logic [5:0] idx;
    req = wb_cyc_i && wb_stb_i && !q.ack;
    wr = req && wb_we_i;
    idx = wb_adr_i[7:2];
    go = 1'b0;
    launch = 1'b0;
    d = q;
    d.ack = req;
    d.dat = '0;

    if (req && wb_adr_i[`DCS_RAM_SEL_BIT]) begin
      // RAM stays writable during a datagram
      d.dat = {20'h0_0000, q.ram[idx]};
      if (wr && wb_sel_i[0]) begin
        d.ram[idx][7:0] = wb_dat_i[7:0];
      end
      if (wr && wb_sel_i[1]) begin
        d.ram[idx][11:8] = wb_dat_i[11:8];
      end
    end else if (req) begin
      unique case (idx)
        `DCS_REG_CTRL: begin
          d.dat[`DCS_CTRL_LAST_LO +: 2] = q.last_idx;
          d.dat[`DCS_CTRL_SCK_POL] = q.sck_pol;
          d.dat[`DCS_CTRL_NCS_POL] = q.ncs_pol;
          d.dat[`DCS_CTRL_DIV_LO +: 8] = q.clk_div;
          if (wr && wb_sel_i[0]) begin
            go = wb_dat_i[`DCS_CTRL_START];
            d.last_idx = wb_dat_i[`DCS_CTRL_LAST_LO +: 2];
            d.sck_pol = wb_dat_i[`DCS_CTRL_SCK_POL];
            d.ncs_pol = wb_dat_i[`DCS_CTRL_NCS_POL];
          end
          if (wr && wb_sel_i[1]) begin
            d.clk_div = wb_dat_i[`DCS_CTRL_DIV_LO +: 8];
          end
        end
        `DCS_REG_STATUS: begin
          d.dat[`DCS_ST_BUSY] = seq_valid || !link_idle;
          d.dat[`DCS_ST_PEND] = q.pend;
          d.dat[`DCS_ST_DAC_LO +: 2] = q.dac;
          d.dat[`DCS_ST_WP_LO +: 6] = q.wp;
        end
        `DCS_REG_RXDATA: d.dat = rx_data;
        `DCS_REG_DGCNT: d.dat = {16'h0000, q.dgcnt};
        default: d.dat = '0;
      endcase
    end

    // Request waits until the chain has fully closed
    launch = q.pend && (q.state == S_IDLE) && link_idle;
    d.pend = go || xmit_req || (q.pend && !launch);

    unique case (q.state)
      S_IDLE: begin
        d.dac = 2'h0;
        if (launch) begin
          d.snap = live;
          d.wp = 6'h00;
          d.dac = 2'h0;
          d.state = S_SEND;
        end
      end
      S_SEND: begin
        if (bit_take) begin
          // Wraps in the config half only
          d.wp = q.wp + 6'h01;
          if (cur_word[`DCS_NXM_BIT]) begin
            if (q.dac == q.last_idx) begin
              d.dac = 2'h0;
              d.state = S_IDLE;
              d.dgcnt = q.dgcnt + 16'h0001;
            end else begin
              d.dac = q.dac + 2'h1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{state: S_IDLE, last_idx: `DCS_RST_LAST,
             clk_div: `DCS_RST_DIV, default: '0};
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
endmodule
`default_nettype wire

// ==== tb/dcs_sequencer_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcs_sequencer_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bus side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Chain side
  input wire logic xmit_req,
  input wire logic chain_sck,
  input wire logic chain_sdo,
  input wire logic chain_sel
);
  // Figures assume clk_div 3 and default polarities, as the bench sets
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_sck_idle: assert property (chain_sel |-> !chain_sck)
    else $error("serial clock moves while deselected");
  a_sdo_steady: assert property (chain_sck |-> $stable(chain_sdo))
    else $error("data changed away from inactive edge");
  a_sck_high_len: assert property (
    $rose(chain_sck) |-> chain_sck[*4] ##1 !chain_sck)
    else $error("serial clock high phase length wrong");
  a_sck_low_len: assert property (
    $fell(chain_sck) |-> (!chain_sck)[*4])
    else $error("serial clock low phase too short");
  a_frame_min: assert property (
    $fell(chain_sel) |-> (!chain_sel)[*8])
    else $error("frame shorter than one bit");
  a_launch_bound: assert property (
    chain_sel[*8] ##0 xmit_req |-> ##[2:6] !chain_sel)
    else $error("request from idle not launched");
  c_ack: cover property (wb_ack_o);
  c_start: cover property ($fell(chain_sel));
  c_end: cover property ($rose(chain_sel));
endmodule
bind dcs_sequencer dcs_sequencer_chk u_chk (.core_clk(core_clk),
  .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .xmit_req(xmit_req),
  .chain_sck(chain_sck), .chain_sdo(chain_sdo), .chain_sel(chain_sel));
`default_nettype wire

// ==== tb/dcs_chain_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcs_chain_model (
  // Chain pins
  input wire logic sck,
  input wire logic sdo,
  input wire logic sel_n,
  output logic sdi
);
  logic got [$];
  logic [7:0] sh = 8'ha5;
  // Bits kept in arrival order for the bench to judge
  always @(posedge sck) if (!sel_n) got.push_back(sdo);
  always @(negedge sck) sh <= {sh[6:0], sh[7]};
  // Pull-up holds the line once the chain is deselected
  assign sdi = sel_n ? 1'h1 : sh[7];
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dcs_pkg::*;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic cyc = 1'h0;
  logic we = 1'h0;
  logic [8:0] adr = 9'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [2:0][7:0] pos = 24'h0;
  logic [2:0] dir = 3'h0;
  logic [2:0] stp = 3'h0;
  logic [2:0] fda = 3'h0;
  logic [2:0] fdb = 3'h0;
  logic req = 1'h0;
  logic [31:0] dat_o;
  logic ack, sck, sdo, csel, sdi;
  int bad_count = 0;
  int checks_done = 0;
  logic [5:0] tbl [64];
  logic [5:0] cfg [64];
  logic exp_q [$];
  always #12.5 core_clk = ~core_clk;
  dcs_sequencer u_dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .motor_pos(pos),
    .motor_dir(dir), .motor_step(stp), .motor_fd_a(fda), .motor_fd_b(fdb),
    .xmit_req(req), .chain_sdi(sdi), .chain_sck(sck), .chain_sdo(sdo),
    .chain_sel(csel));
  dcs_chain_model u_chain (.sck(sck), .sdo(sdo), .sel_n(csel), .sdi(sdi));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
    rd = dat_o;
    cyc <= 1'h0;
  endtask
  task automatic wait_sel(input logic v, input int lim);
    for (int n = 0; csel !== v; n++) begin
      @(posedge core_clk);
      if (n > lim) begin
        bad_count++;
        tally_and_finish();
      end
    end
  endtask
  task automatic pulse_req();
    @(posedge core_clk);
    req <= 1'h1;
    @(posedge core_clk);
    req <= 1'h0;
  endtask
  task automatic rand_motor();
    @(posedge core_clk);
    pos <= 24'($urandom);
    dir <= 3'($urandom);
    stp <= 3'($urandom);
    fda <= 3'($urandom);
    fdb <= 3'($urandom);
  endtask
  // Coil B reads the table a quarter period ahead of coil A
  function automatic logic pick(int m, logic [4:0] c);
    logic [7:0] p;
    logic [5:0] i;
    p = pos[m] + (c[3] ? 8'h40 : 8'h00);
    i = p[6] ? ~p[5:0] : p[5:0];
    if (c[4])
      return c == 5'h11 || (c == 5'h12 && dir[m]) || (c == 5'h13 && stp[m]);
    if (c[2:0] == 3'h6)
      return p[7];
    if (c[2:0] == 3'h7)
      return c[3] ? fdb[m] : fda[m];
    return tbl[i][c[2:0]];
  endfunction
  task automatic build(input logic [1:0] last);
    int m;
    m = 0;
    exp_q = {};
    for (int k = 0; k < 64; k++) begin
      exp_q.push_back(pick(m, cfg[k][4:0]));
      if (cfg[k][5] && m == last)
        break;
      if (cfg[k][5])
        m++;
    end
  endtask
  task automatic check_frame();
    cmp(32'(u_chain.got.size()), 32'(exp_q.size()));
    foreach (exp_q[k]) cmp({31'h0, u_chain.got[k]}, {31'h0, exp_q[k]});
  endtask
  task automatic run(input logic [1:0] last);
    rand_motor();
    u_chain.got = {};
    bus(1'h1, 9'h000, {16'h0, 8'h03, 4'h0, last, 1'h0, last != 2'h2});
    if (last == 2'h2)
      pulse_req();
    build(last);
    wait_sel(1'h0, 12);
    rand_motor();
    pulse_req();
    pulse_req();
    wait_sel(1'h1, 900);
    check_frame();
    build(last);
    u_chain.got = {};
    wait_sel(1'h0, 12);
    wait_sel(1'h1, 900);
    check_frame();
    repeat (40) @(posedge core_clk);
    cmp({31'h0, csel}, 32'h1);
    $display("datagram test last %0d done", last);
  endtask
  initial begin
    void'($urandom(32'h2aea));
    repeat (5) @(posedge core_clk);
    nrst <= 1'h1;
    for (int i = 0; i < 64; i++) begin
      tbl[i] = 6'($urandom);
      cfg[i] = {i == 10 || i == 20 || i == 31, 5'(i)};
    end
    for (int i = 0; i < 64; i++)
      bus(1'h1, {1'h1, 6'(i), 2'h0}, i < 32 ?
        {20'h0, cfg[2*i+1], cfg[2*i]} : {20'h0, tbl[2*i-63], tbl[2*i-64]});
    bus(1'h0, 9'h114, 32'h0);
    cmp(rd, {20'h0, cfg[11], cfg[10]});
    bus(1'h0, 9'h1a0, 32'h0);
    cmp(rd, {20'h0, tbl[17], tbl[16]});
    $display("ram readback test done");
    for (int l = 0; l < 3; l++)
      run(2'(l));
    bus(1'h0, 9'h00c, 32'h0);
    cmp(rd, 32'h6);
    // Model repeats its byte every 8 bits; 128 bits have been sent
    bus(1'h0, 9'h008, 32'h0);
    cmp(rd, {4{8'ha5}});
    bus(1'h0, 9'h004, 32'h0);
    cmp(rd & 32'h33, 32'h0);
    bus(1'h0, 9'h0fc, 32'h0);
    cmp(rd, 32'h0);
    $display("status test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
